// *** design/smd_map.svh ***
// address map, strap timing and reset constants of the memory decoder
// Function
// R1 - low 4M internal, top 4M peripherals, rest external
// R2 - 0x00400000 up to 0xFFC00000 goes external
// R3 - little-endian byte order everywhere, no option
// R4 - 8K SRAM, 32 bits, single cycle
// R5 - boot width strap: 1 = 8-bit, 0 = 16-bit
// R6 - boot memory at zero until remap, then SRAM
// R7 - remap command bit write performs the remap
// R8 - chip selects 1..7 reachable only after remap
// R9 - remap held until internal or pin reset
// R10 - abort on undefined external address
// R11 - no abort for internal or peripheral accesses
// R12 - banks of 1M up to 16M, any alignment; code aligns each bank to its size
// R13 - per bank wait states, float cycles, width
// R14 - 16-bit bank: byte select or byte write
// R15 - early read option for all banks
// R16 - peripheral accesses forced to aligned words
// R17 - 16K peripheral windows, 4K interrupt controller
// R18 - tristate when strap low last 10 cycles
// R19 - board keeps tristate strap high in reset
// R20 - watchdog reset keeps both latched straps
// R21 - reset pin release synchronised to clock
// R22 - pin reset clears remap, relatches straps
// R23 - one region per access, decoded combinationally
`ifndef SMD_MAP_SVH
`define SMD_MAP_SVH
`define SMD_INT_TOP 32'h0040_0000
`define SMD_PERI_BASE 32'hffc0_0000
`define SMD_IRQCTL_PAGE 20'hfffff
`define SMD_PERI_IDX_LSB 14
`define SMD_STRAP_CYCLES 4'ha
`define SMD_SIZE_MAX 3'h4
`define SMD_CS_IDLE 8'hff
`define SMD_BOOT8_RST 1'b0
`define SMD_TRI_RST 1'b0
`endif

// *** design/smd_pkg.sv ***
// types of the memory decoder
package smd_pkg;

    typedef enum logic [1:0] {
        SMD_BYTE = 2'b00,
        SMD_HALF = 2'b01,
        SMD_WORD = 2'b10
    } smd_size_t;

    typedef enum logic [1:0] {
        SMD_SRAM = 2'b00,
        SMD_EXT = 2'b01,
        SMD_PERI = 2'b10,
        SMD_NONE = 2'b11
    } smd_region_t;

    typedef enum logic [2:0] {
        SMD_IDLE = 3'b000,
        SMD_PACC = 3'b001,
        SMD_SETUP = 3'b010,
        SMD_STROBE = 3'b011,
        SMD_FLOAT = 3'b100
    } smd_phase_t;

    typedef struct packed {
        smd_phase_t phase;
        logic rst_meta;
        logic rst_sync;
        logic pin_low_q;
        logic remap;
        logic boot8;
        logic tristate;
        logic boot_sample;
        logic [3:0] low_cnt;
        logic [2:0] cnt;
        logic [2:0] beats;
        logic [2:0] bank;
        logic [2:0] wait_cfg;
        logic [2:0] float_cfg;
        logic width16;
        logic byte_write;
        logic early;
        logic is_write;
        logic is_byte;
        logic [1:0] lanes;
        logic [1:0] beat_off;
        logic [23:0] beat_addr;
        logic [31:0] wsh;
        logic [31:0] acc;
        logic ready;
        logic abort;
        logic busy;
        logic [31:0] rdata;
        smd_region_t region;
        logic peri_req;
        logic peri_write;
        logic peri_irqctl;
        logic [7:0] peri_index;
        logic [31:0] peri_addr;
        logic [31:0] peri_wdata;
        logic [7:0] cs_n;
        logic [23:0] ext_addr;
        logic [15:0] ext_wdata;
        logic oe_n;
        logic [1:0] we_n;
        logic [1:0] bs_n;
        logic pin_oe;
        logic data_oe;
    } smd_state_t;

endpackage

// *** design/smd_sram.sv ***
// internal word-wide SRAM with byte lanes and registered read data
`timescale 1ns/1ps
module smd_sram #(
    parameter int ADDR_W = 11
) (
    input wire logic clk_i,
    input wire logic en_i,
    input wire logic we_i,
    input wire logic [3:0] be_i,
    input wire logic [ADDR_W-1:0] addr_i,
    input wire logic [31:0] wdata_i,
    output logic [31:0] rdata_o
);
    logic [31:0] mem [0:(1<<ADDR_W)-1];

    // no reset on the array; read data shows the old word on a write
    always_ff @(posedge clk_i) begin
        if (en_i) begin
            for (int b = 0; b < 4; b++) begin
                if (we_i && be_i[b]) begin
                    mem[addr_i][8*b +: 8] <= wdata_i[8*b +: 8];
                end
            end
            rdata_o <= mem[addr_i];
        end
    end
endmodule

// *** design/smd_decoder.sv ***
// memory decoder: region decode, straps, remap, external bank sequencer
`timescale 1ns/1ps
`include "smd_map.svh"
module smd_decoder #(
    parameter int SRAM_ADDR_W = 11
) (
    input wire logic CLOCK_I,
    input wire logic SRST_I,
    input wire logic RESET_PIN_N_I,
    input wire logic WATCHDOG_RESET_I,
    input wire logic BOOT_WIDTH_STRAP_I,
    input wire logic TRISTATE_STRAP_N_I,
    input wire logic REMAP_CMD_I,
    input wire logic REQ_I,
    input wire logic WRITE_I,
    input smd_pkg::smd_size_t SIZE_I,
    input wire logic [31:0] ADDR_I,
    input wire logic [31:0] WDATA_I,
    input wire logic [7:0] BANK_ENABLE_I,
    input wire logic [95:0] BANK_BASE_I,
    input wire logic [23:0] BANK_SIZE_I,
    input wire logic [23:0] BANK_WAIT_I,
    input wire logic [23:0] BANK_FLOAT_I,
    input wire logic [7:0] BANK_WIDTH16_I,
    input wire logic [7:0] BANK_BYTE_WRITE_I,
    input wire logic EARLY_READ_I,
    input wire logic [15:0] EXT_RDATA_I,
    input wire logic [31:0] PERI_RDATA_I,
    output logic READY_O,
    output logic ABORT_O,
    output logic BUSY_O,
    output logic [31:0] RDATA_O,
    output logic [31:0] SRAM_RDATA_O,
    output smd_pkg::smd_region_t REGION_O,
    output logic REMAPPED_O,
    output logic BOOT_WIDTH8_O,
    output logic TRISTATE_O,
    output logic PERI_REQ_O,
    output logic PERI_WRITE_O,
    output logic PERI_IRQCTL_SEL_O,
    output logic [7:0] PERI_INDEX_O,
    output logic [31:0] PERI_ADDR_O,
    output logic [31:0] PERI_WDATA_O,
    output logic [7:0] EXT_CS_N_O,
    output logic [23:0] EXT_ADDR_O,
    output logic [15:0] EXT_WDATA_O,
    output logic EXT_OE_N_O,
    output logic [1:0] EXT_WE_N_O,
    output logic [1:0] EXT_BS_N_O,
    output logic EXT_PIN_OE_O,
    output logic EXT_DATA_OE_O
);
    import smd_pkg::*;

    smd_state_t s;
    smd_state_t n;

    logic pin_low;
    logic int_rst;
    logic take;
    logic in_low;
    logic in_peri;
    logic hit;
    logic [2:0] hb;
    logic [11:0] bmask;
    logic [23:0] off;
    logic w16;
    logic [3:0] be;
    logic sram_en;
    smd_region_t rgn;
    logic [15:0] rd16;
    logic [1:0] sh;
    logic [1:0] step;

    function automatic logic [11:0] bank_mask(input logic [2:0] code);
        logic [2:0] c;
        c = (code > `SMD_SIZE_MAX) ? `SMD_SIZE_MAX : code;
        return 12'hfff << c;
    endfunction

    ////////////////////////////////////////////////////////////////////////
    // address decode

    always_comb begin
        in_low = ADDR_I < `SMD_INT_TOP; // see R1
        in_peri = ADDR_I >= `SMD_PERI_BASE; // see R1
        hit = 1'b0;
        hb = 3'h0;
        // lowest matching bank wins when software overlaps windows
        for (int i = 7; i >= 0; i--) begin
            if (BANK_ENABLE_I[i] &&
                (((ADDR_I[31:20] ^ BANK_BASE_I[12*i +: 12]) &
                  bank_mask(BANK_SIZE_I[3*i +: 3])) == 12'h000)) begin // see R12
                hit = 1'b1;
                hb = 3'(i);
            end
        end
        if (!s.remap) begin
            // only the boot device answers before the remap
            hit = in_low || (hit && hb == 3'h0); // see R8
            hb = 3'h0;
        end
        if (in_peri) begin
            rgn = SMD_PERI;
        end else if (in_low && s.remap) begin
            rgn = SMD_SRAM; // see R6
        end else begin
            rgn = SMD_EXT; // see R2
        end // see R23
        bmask = bank_mask(BANK_SIZE_I[3*hb +: 3]);
        off = ADDR_I[23:0] & {~bmask[3:0], 20'hfffff};
        // boot device width comes from the latched strap
        w16 = (!s.remap && hb == 3'h0) ? !s.boot8 : BANK_WIDTH16_I[hb]; // see R5
        case (SIZE_I)
            SMD_BYTE: be = 4'h1 << ADDR_I[1:0];
            SMD_HALF: be = ADDR_I[1] ? 4'hc : 4'h3;
            default: be = 4'hf;
        endcase
    end

    ////////////////////////////////////////////////////////////////////////
    // reset, straps and access sequencing

    always_comb begin
        n = s;
        // two-stage synchroniser, release seen on the clock
        n.rst_meta = RESET_PIN_N_I; // see R21
        n.rst_sync = s.rst_meta;
        pin_low = !s.rst_sync;
        int_rst = pin_low || WATCHDOG_RESET_I;
        n.pin_low_q = pin_low;
        take = REQ_I && !s.busy && !int_rst;
        sram_en = take && rgn == SMD_SRAM;
        n.ready = 1'b0;
        n.abort = 1'b0;
        n.peri_req = 1'b0;
        rd16 = s.width16 ?
            {EXT_RDATA_I[15:8] & {8{s.lanes[1]}}, EXT_RDATA_I[7:0] & {8{s.lanes[0]}}} :
            {8'h00, EXT_RDATA_I[7:0]};
        sh = s.width16 ? {s.beat_off[1], 1'b0} : s.beat_off;
        step = s.width16 ? 2'h2 : 2'h1;

        if (pin_low) begin
            // straps watched only while the pin holds reset
            n.boot_sample = BOOT_WIDTH_STRAP_I; // see R5
            if (TRISTATE_STRAP_N_I) begin
                n.low_cnt = 4'h0; // see R19
            end else if (s.low_cnt != `SMD_STRAP_CYCLES) begin
                n.low_cnt = s.low_cnt + 4'h1; // see R18
            end
        end else if (s.pin_low_q) begin
            // watchdog resets never reach this branch
            n.boot8 = s.boot_sample; // see R22 R20
            n.tristate = s.low_cnt == `SMD_STRAP_CYCLES; // see R18
        end

        if (int_rst) begin
            n.remap = 1'b0; // see R22 R9
            n.phase = SMD_IDLE;
        end else begin
            if (REMAP_CMD_I) begin
                n.remap = 1'b1; // see R7 R9
            end
            case (s.phase)
                SMD_IDLE: begin
                    if (take) begin
                        n.region = rgn;
                        if (rgn == SMD_SRAM) begin
                            n.ready = 1'b1; // see R4
                        end else if (rgn == SMD_PERI) begin
                            n.phase = SMD_PACC;
                            n.peri_req = 1'b1;
                            n.peri_write = WRITE_I;
                            n.peri_addr = {ADDR_I[31:2], 2'b00}; // see R16
                            n.peri_wdata = WDATA_I;
                            n.peri_index = ADDR_I[`SMD_PERI_IDX_LSB +: 8]; // see R17
                            n.peri_irqctl = ADDR_I[31:12] == `SMD_IRQCTL_PAGE; // see R17
                        end else if (!hit) begin
                            n.ready = 1'b1;
                            n.abort = 1'b1; // see R10
                        end else begin
                            n.bank = hb;
                            n.width16 = w16; // see R13
                            n.wait_cfg = BANK_WAIT_I[3*hb +: 3]; // see R13
                            n.float_cfg = BANK_FLOAT_I[3*hb +: 3]; // see R13
                            n.byte_write = BANK_BYTE_WRITE_I[hb]; // see R14
                            n.early = EARLY_READ_I; // see R15
                            n.is_write = WRITE_I;
                            n.is_byte = SIZE_I == SMD_BYTE;
                            n.beat_addr = off;
                            n.beat_off = ADDR_I[1:0];
                            n.wsh = WDATA_I >> {ADDR_I[1:0], 3'b000};
                            n.acc = 32'h0000_0000;
                            n.cnt = BANK_WAIT_I[3*hb +: 3];
                            if (!w16) begin
                                n.lanes = 2'b01;
                                n.beats = (SIZE_I == SMD_WORD) ? 3'h4 :
                                          (SIZE_I == SMD_HALF) ? 3'h2 : 3'h1;
                            end else begin
                                n.lanes = (SIZE_I != SMD_BYTE) ? 2'b11 :
                                          ADDR_I[0] ? 2'b10 : 2'b01;
                                n.beats = (SIZE_I == SMD_WORD) ? 3'h2 : 3'h1;
                            end
                            // early read drops the setup cycle
                            n.phase = EARLY_READ_I ? SMD_STROBE : SMD_SETUP; // see R15
                        end
                    end
                end
                SMD_PACC: begin
                    n.ready = 1'b1; // see R11
                    n.rdata = PERI_RDATA_I;
                    n.phase = SMD_IDLE;
                end
                SMD_SETUP: begin
                    n.phase = SMD_STROBE;
                end
                SMD_STROBE: begin
                    if (s.cnt != 3'h0) begin
                        n.cnt = s.cnt - 3'h1; // see R13
                    end else begin
                        // lower address beats land in lower bytes
                        n.acc = s.acc | ({16'h0000, rd16} << {sh, 3'b000}); // see R3
                        if (s.beats == 3'h1) begin
                            n.ready = 1'b1;
                            n.rdata = n.acc;
                            if (s.float_cfg != 3'h0) begin
                                n.phase = SMD_FLOAT; // see R13
                                n.cnt = s.float_cfg - 3'h1;
                            end else begin
                                n.phase = SMD_IDLE;
                            end
                        end else begin
                            n.beats = s.beats - 3'h1;
                            n.beat_addr = s.beat_addr + {22'h000000, step};
                            n.beat_off = s.beat_off + step;
                            n.wsh = s.wsh >> {step, 3'b000}; // see R3
                            n.cnt = s.wait_cfg;
                            n.phase = s.early ? SMD_STROBE : SMD_SETUP;
                        end
                    end
                end
                SMD_FLOAT: begin
                    // bus left idle so a slow device can let go
                    if (s.cnt == 3'h0) begin
                        n.phase = SMD_IDLE;
                    end else begin
                        n.cnt = s.cnt - 3'h1;
                    end
                end
                default: begin
                    n.phase = SMD_IDLE;
                end
            endcase
        end
        n.busy = int_rst || n.phase != SMD_IDLE;

        // pin drive follows the next state so outputs leave flops
        n.cs_n = `SMD_CS_IDLE;
        n.oe_n = 1'b1;
        n.we_n = 2'b11;
        n.bs_n = 2'b11;
        n.data_oe = 1'b0;
        if (n.phase == SMD_SETUP || n.phase == SMD_STROBE) begin
            n.cs_n[n.bank] = 1'b0;
            n.bs_n = n.byte_write ? 2'b00 : ~n.lanes; // see R14
            n.data_oe = n.is_write && !n.tristate; // see R18
            if (n.phase == SMD_STROBE) begin
                if (!n.is_write) begin
                    n.oe_n = 1'b0;
                end else if (n.width16 && n.byte_write) begin
                    n.we_n = ~n.lanes; // see R14
                end else begin
                    n.we_n = 2'b10;
                end
            end
        end
        n.ext_addr = n.beat_addr;
        n.ext_wdata = (n.width16 && n.is_byte) ? {2{n.wsh[7:0]}} : n.wsh[15:0];
        n.pin_oe = !n.tristate; // see R18
    end

    always_ff @(posedge CLOCK_I) begin
        if (SRST_I) begin
            s <= '0;
            s.pin_low_q <= 1'b1;
            s.busy <= 1'b1;
            s.boot8 <= `SMD_BOOT8_RST;
            s.tristate <= `SMD_TRI_RST;
            s.region <= SMD_NONE;
            s.cs_n <= `SMD_CS_IDLE;
            s.oe_n <= 1'b1;
            s.we_n <= 2'b11;
            s.bs_n <= 2'b11;
            s.pin_oe <= 1'b1;
        end else begin
            s <= n;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // internal memory

    smd_sram #(
        .ADDR_W(SRAM_ADDR_W)
    ) u_sram (
        .clk_i(CLOCK_I),
        .en_i(sram_en),
        .we_i(WRITE_I),
        .be_i(be),
        .addr_i(ADDR_I[SRAM_ADDR_W+1:2]),
        .wdata_i(WDATA_I),
        .rdata_o(SRAM_RDATA_O)
    ); // see R4

    assign READY_O = s.ready;
    assign ABORT_O = s.abort;
    assign BUSY_O = s.busy;
    assign RDATA_O = s.rdata;
    assign REGION_O = s.region;
    assign REMAPPED_O = s.remap;
    assign BOOT_WIDTH8_O = s.boot8;
    assign TRISTATE_O = s.tristate;
    assign PERI_REQ_O = s.peri_req;
    assign PERI_WRITE_O = s.peri_write;
    assign PERI_IRQCTL_SEL_O = s.peri_irqctl;
    assign PERI_INDEX_O = s.peri_index;
    assign PERI_ADDR_O = s.peri_addr;
    assign PERI_WDATA_O = s.peri_wdata;
    assign EXT_CS_N_O = s.cs_n;
    assign EXT_ADDR_O = s.ext_addr;
    assign EXT_WDATA_O = s.ext_wdata;
    assign EXT_OE_N_O = s.oe_n;
    assign EXT_WE_N_O = s.we_n;
    assign EXT_BS_N_O = s.bs_n;
    assign EXT_PIN_OE_O = s.pin_oe;
    assign EXT_DATA_OE_O = s.data_oe;

    ////////////////////////////////////////////////////////////////////////
    // checks

    peri_word_a: assert property (@(posedge CLOCK_I) disable iff (SRST_I) // see R16
        take && in_peri |=> PERI_REQ_O && PERI_ADDR_O == {$past(ADDR_I[31:2]), 2'b00})
        else $error("peripheral access not word aligned");
    peri_noabort_a: assert property (@(posedge CLOCK_I) disable iff (SRST_I) // see R11
        take && in_peri && !WATCHDOG_RESET_I |=> !ABORT_O ##1 (READY_O && !ABORT_O))
        else $error("peripheral access aborted or unanswered");
    sram_single_a: assert property (@(posedge CLOCK_I) disable iff (SRST_I) // see R4
        take && in_low && s.remap |=> READY_O && !ABORT_O && EXT_CS_N_O == 8'hff)
        else $error("internal memory access not single cycle");
    boot_cs0_a: assert property (@(posedge CLOCK_I) disable iff (SRST_I) // see R6
        take && in_low && !s.remap |=> !EXT_CS_N_O[0] && !ABORT_O)
        else $error("boot memory not at address zero");
    undef_abort_a: assert property (@(posedge CLOCK_I) disable iff (SRST_I) // see R10
        take && rgn == SMD_EXT && !hit |=> ABORT_O && READY_O && EXT_CS_N_O == 8'hff)
        else $error("undefined external address not aborted");
    remap_set_a: assert property (@(posedge CLOCK_I) disable iff (SRST_I) // see R7
        REMAP_CMD_I && !int_rst |=> REMAPPED_O)
        else $error("remap command ignored");
    remap_hold_a: assert property (@(posedge CLOCK_I) disable iff (SRST_I) // see R9
        REMAPPED_O && s.rst_sync && !WATCHDOG_RESET_I |=> REMAPPED_O)
        else $error("remap undone without reset");
    tri_latch_a: assert property (@(posedge CLOCK_I) disable iff (SRST_I) // see R18
        s.pin_low_q && s.rst_sync |=> TRISTATE_O == ($past(s.low_cnt) == 4'ha))
        else $error("tristate strap latched wrongly");
    wdog_keep_a: assert property (@(posedge CLOCK_I) disable iff (SRST_I) // see R20
        WATCHDOG_RESET_I && s.rst_sync && !s.pin_low_q |=>
            $stable(TRISTATE_O) && $stable(BOOT_WIDTH8_O))
        else $error("watchdog reset changed strap modes");
endmodule

// *** dv/smd_ext_model.sv ***
// board model: external memories on the chip selects and the peripheral bus
`timescale 1ns/1ps
module smd_ext_model #(
    parameter logic [7:0] BW = 8'h04
) (
    input wire logic clk_i,
    input wire logic [7:0] cs_n_i,
    input wire logic [23:0] a_i,
    input wire logic [15:0] wd_i,
    input wire logic oe_n_i,
    input wire logic [1:0] we_n_i,
    input wire logic [1:0] bs_n_i,
    input wire logic [7:0] w16_i,
    input wire logic pr_i,
    input wire logic [31:0] pa_i,
    output logic [15:0] rd_o,
    output logic [31:0] prd_o
);
    logic [7:0] mem [0:1023];
    logic [15:0] last = 16'h0;
    logic [31:0] plast = 32'h0;
    logic [2:0] cs;
    logic [9:0] a;
    logic [1:0] wl;
    logic sel, w;
    initial begin
        for (int i = 0; i < 1024; i++) begin
            mem[i] = 8'(i) ^ 8'h3c;
        end
    end
    always_comb begin
        cs = 3'h0;
        for (int i = 7; i >= 0; i--) begin
            if (!cs_n_i[i]) begin
                cs = 3'(i);
            end
        end
    end
    assign sel = ~&cs_n_i;
    assign w = w16_i[cs];
    assign a = {cs, a_i[6:1], a_i[0] & ~w};
    // paired 8-bit parts obey own strobes, a 16-bit part its byte selects
    assign wl = !sel ? 2'b00 : !w ? {1'b0, ~&we_n_i} :
        BW[cs] ? ~we_n_i : {2{~&we_n_i}} & ~bs_n_i;
    always @(posedge clk_i) begin
        if (wl[0]) mem[a] <= wd_i[7:0];
        if (wl[1]) mem[a + 10'h1] <= wd_i[15:8];
        last <= rd_o;
        plast <= prd_o;
    end
    // released buses never keep a stale value; low lane is the low address
    assign rd_o = (!sel || oe_n_i) ? ~last :
        w ? {mem[a + 10'h1], mem[a]} : {~last[15:8], mem[a]};
    assign prd_o = pr_i ? pa_i ^ 32'h5a5a_0f0f : ~plast;
endmodule

// *** dv/smd_decoder_bench.sv ***
// self-checking bench of the memory decoder against the board model
`timescale 1ns/1ps
`define CHK(a, e) begin check_count++; if ((a) !== (e)) begin n_mismatch++; \
    $display("[ERR] %0t got %h exp %h", $time, (a), (e)); end end
module smd_decoder_bench;
    import smd_pkg::*;
    logic clk = 1'b0, srst = 1'b1, pin_n = 1'b1, wdog = 1'b0, bst = 1'b1, tst_n = 1'b1;
    logic rmp = 1'b0, req = 1'b0, wr = 1'b0, early = 1'b0, ab;
    smd_size_t sz = SMD_WORD;
    logic [31:0] adr = 32'h0, wd = 32'h0, ba;
    logic [7:0] en = 8'h0f;
    logic [23:0] wt = 24'h000408;
    logic rdy, abt, busy, rmpd, b8, tri_o, preq, pwr, pirq, oe_n, pin_oe, doe, dseen;
    logic [31:0] rdata, srdata, prd, padr, pwd;
    logic [23:0] xa;
    logic [15:0] xwd, xrd;
    logic [7:0] pidx, cs_n, cs_seen;
    logic [1:0] we_n, bs_n;
    smd_region_t region;
    int lat, flt, n_mismatch = 0, check_count = 0;
    localparam logic [23:0] fl = 24'h000211;
    localparam logic [7:0] w16c = 8'h06;
    always #12.5 clk = ~clk;
    smd_decoder #(.SRAM_ADDR_W(11)) u_smd_decoder (
        .CLOCK_I(clk), .SRST_I(srst), .RESET_PIN_N_I(pin_n), .WATCHDOG_RESET_I(wdog),
        .BOOT_WIDTH_STRAP_I(bst), .TRISTATE_STRAP_N_I(tst_n), .REMAP_CMD_I(rmp),
        .REQ_I(req), .WRITE_I(wr), .SIZE_I(sz), .ADDR_I(adr), .WDATA_I(wd),
        .BANK_ENABLE_I(en), .BANK_BASE_I(96'h030020010004), .BANK_SIZE_I(24'h000800),
        .BANK_WAIT_I(wt), .BANK_FLOAT_I(fl), .BANK_WIDTH16_I(w16c),
        .BANK_BYTE_WRITE_I(8'h04), .EARLY_READ_I(early), .EXT_RDATA_I(xrd),
        .PERI_RDATA_I(prd), .READY_O(rdy), .ABORT_O(abt), .BUSY_O(busy), .RDATA_O(rdata),
        .SRAM_RDATA_O(srdata), .REGION_O(region), .REMAPPED_O(rmpd), .BOOT_WIDTH8_O(b8),
        .TRISTATE_O(tri_o), .PERI_REQ_O(preq), .PERI_WRITE_O(pwr),
        .PERI_IRQCTL_SEL_O(pirq), .PERI_INDEX_O(pidx), .PERI_ADDR_O(padr),
        .PERI_WDATA_O(pwd), .EXT_CS_N_O(cs_n), .EXT_ADDR_O(xa), .EXT_WDATA_O(xwd),
        .EXT_OE_N_O(oe_n), .EXT_WE_N_O(we_n), .EXT_BS_N_O(bs_n), .EXT_PIN_OE_O(pin_oe),
        .EXT_DATA_OE_O(doe)
    );
    // boot bank width follows the strap until remap
    smd_ext_model u_smd_ext_model (
        .clk_i(clk), .cs_n_i(cs_n), .a_i(xa), .wd_i(xwd), .oe_n_i(oe_n), .we_n_i(we_n),
        .bs_n_i(bs_n), .w16_i({w16c[7:1], rmpd ? w16c[0] : ~b8}), .pr_i(preq),
        .pa_i(padr), .rd_o(xrd), .prd_o(prd)
    );
    ////////////////////////////////////////////////////////////////////////////////
    task automatic complete_run;
        $display("compares %0d mismatches %0d", check_count, n_mismatch);
        if (n_mismatch == 0 && check_count > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask
    task automatic wait_idle;
        int n;
        n = 0;
        while (busy !== 1'b0 && n < 100) begin
            @(posedge clk);
            n++;
        end
    endtask
    // request held until taken; latency counted in edges after the taking edge
    task automatic acc(input logic w, input smd_size_t s, input logic [31:0] a,
                       input logic [31:0] d);
        int n;
        n = 0;
        req <= 1'b1;
        wr <= w;
        sz <= s;
        adr <= a;
        wd <= d;
        cs_seen = 8'h00;
        dseen = 1'b0;
        do begin
            @(posedge clk);
            n++;
        end while (busy !== 1'b0 && n < 200);
        req <= 1'b0;
        lat = 0;
        do begin
            @(posedge clk);
            lat++;
            cs_seen |= ~cs_n;
            dseen |= doe;
        end while (rdy !== 1'b1 && lat < 200);
        ab = abt;
        flt = 0;
        while (busy !== 1'b0 && flt < 50) begin
            @(posedge clk);
            flt++;
        end
    endtask
    function automatic logic [31:0] xw(input int c, input int o);
        logic [31:0] v;
        for (int i = 3; i >= 0; i--)
            v = {v[23:0], 8'(c * 128 + o + i) ^ 8'h3c};
        return v;
    endfunction
    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        repeat (5) @(posedge clk);
        srst <= 1'b0;
        wait_idle();
        `CHK(region, SMD_NONE)
        `CHK({rmpd, b8, tri_o, pin_oe}, 4'b0101)
        acc(1'b0, SMD_WORD, 32'h4, 0);
        `CHK({rdata, cs_seen, region}, {xw(0, 4), 8'h01, SMD_EXT})
        `CHK(lat, 9)
        acc(1'b0, SMD_WORD, 32'h0100_0000, 0);
        `CHK({ab, cs_seen}, 9'h100)
        rmp <= 1'b1;
        @(posedge clk);
        rmp <= 1'b0;
        @(posedge clk);
        `CHK(rmpd, 1'b1)
        acc(1'b1, SMD_WORD, 32'h0, 32'h1122_3344);
        `CHK({region, lat}, {SMD_SRAM, 32'd1})
        acc(1'b1, SMD_BYTE, 32'h1, 32'h0000_aa00);
        acc(1'b0, SMD_WORD, 32'h0, 0);
        `CHK({srdata, ab}, {32'h1122_aa44, 1'b0})
        acc(1'b0, SMD_WORD, 32'h003f_fffc, 0);
        `CHK({region, ab}, {SMD_SRAM, 1'b0})
        acc(1'b0, SMD_WORD, 32'hffbf_fffc, 0);
        `CHK({region, ab}, {SMD_EXT, 1'b1})
        for (int b = 1; b < 4; b++) begin
            ba = (32'(b) << 24) + (b == 3 ? 32'h00f0_0000 : 32'h0);
            acc(1'b0, SMD_WORD, ba + 8, 0);
            `CHK({rdata, cs_seen}, {xw(b, 8), 8'(1 << b)})
            `CHK(lat, 1 + (w16c[b] ? 2 : 4) * (wt[3*b+:3] + 2))
            `CHK(flt, fl[3*b+:3])
            acc(1'b1, SMD_WORD, ba + 32, 32'hc0de_5a00 + b);
            `CHK(dseen, 1'b1)
            acc(1'b1, SMD_BYTE, ba + 33, 32'h0000_7700);
            acc(1'b0, SMD_WORD, ba + 32, 0);
            `CHK(rdata, 32'hc0de_7700 + b)
        end
        early <= 1'b1;
        wt <= 24'h000400;
        acc(1'b0, SMD_WORD, 32'h0100_0000, 0);
        `CHK(lat, 3)
        early <= 1'b0;
        en <= 8'h0b;
        acc(1'b1, SMD_WORD, 32'h0200_0000, 0);
        `CHK({ab, cs_seen, lat}, {9'h100, 32'd1})
        acc(1'b0, SMD_WORD, 32'h0110_0000, 0);
        `CHK({ab, cs_seen}, 9'h100)
        en <= 8'h0f;
        acc(1'b0, SMD_BYTE, 32'hfffc_4003, 0);
        `CHK({padr, pidx, pirq, pwr}, {32'hfffc_4000, 8'hf1, 2'b00})
        `CHK({rdata, ab, lat}, {32'hfffc_4000 ^ 32'h5a5a_0f0f, 1'b0, 32'd2})
        acc(1'b1, SMD_HALF, 32'hffff_f002, 32'h1234_0000);
        `CHK({padr, pidx, pirq, pwr, pwd}, {40'hffff_f000_ff, 2'b11, 32'h1234_0000})
        `CHK({region, ab, rmpd}, {SMD_PERI, 2'b01})
        // watchdog must not touch the latched straps
        bst <= 1'b0;
        tst_n <= 1'b0;
        wdog <= 1'b1;
        repeat (12) @(posedge clk);
        wdog <= 1'b0;
        wait_idle();
        `CHK({rmpd, b8, tri_o, pin_oe}, 4'b0101)
        pin_n <= 1'b0;
        repeat (15) @(posedge clk);
        pin_n <= 1'b1;
        wait_idle();
        `CHK({rmpd, b8, tri_o, pin_oe}, 4'b0010)
        // remap again so the next pin reset has something to clear
        rmp <= 1'b1;
        @(posedge clk);
        rmp <= 1'b0;
        acc(1'b1, SMD_WORD, 32'h0040_0040, 0);
        `CHK({rmpd, dseen}, 2'b10)
        tst_n <= 1'b1;
        pin_n <= 1'b0;
        repeat (10) @(posedge clk);
        tst_n <= 1'b0;
        repeat (5) @(posedge clk);
        pin_n <= 1'b1;
        tst_n <= 1'b1;
        wait_idle();
        `CHK({rmpd, b8, tri_o, pin_oe}, 4'b0001)
        acc(1'b0, SMD_WORD, 32'h4, 0);
        `CHK({rdata, lat}, {xw(0, 4), 32'd5})
        complete_run();
    end
    initial begin
        repeat (5000) @(posedge clk);
        n_mismatch++;
        complete_run();
    end
endmodule
